// ### rtl/lin_phy_params.svh
// offsets, field positions, reset values and timing counts of the bus physical-layer control
`ifndef LIN_PHY_PARAMS_SVH
`define LIN_PHY_PARAMS_SVH

`define CLK_FREQ_HZ 25000000
`define CTL_OFFSET 8'h50
`define STAT_HI_OFFSET 8'h52
`define STAT_LO_OFFSET 8'h53
`define TX_DEF_OFFSET 8'h54
`define RX_DEF_OFFSET 8'h55
`define WAKE_SRC_OFFSET 8'h58
`define LOWPOWER_OFFSET 8'h59

`define CTL_OVERTEMP_IRQ_ENABLE_BIT 7
`define CTL_TXD_BIT 4
`define CTL_LOW_VOLTAGE_SHUTDOWN_DISABLE_BIT 3
`define CTL_EN_BIT 2
`define CTL_SRS_LSB 0
`define CTL_MASK_SHIFT 8
`define CTL_RESET 16'h0000

`define STAT_OT_BIT 7
`define STAT_UV_BIT 3
`define STAT_RDY_BIT 7
`define STAT_RX_BIT 1
`define STAT_TX_BIT 0

`define SRS_RESET 2'h0
`define READY_TIME_US 50
`define READY_CYCLES ((`READY_TIME_US * (`CLK_FREQ_HZ / 1000)) / 1000)
`define WAKE_DOM_TIME_US 150
`define WAKE_DOM_CYCLES ((`WAKE_DOM_TIME_US * (`CLK_FREQ_HZ / 1000) + 999) / 1000)

`endif

// ### rtl/lin_phy_pkg.sv
// types shared by the bus physical-layer control
package lin_phy_pkg;
	typedef enum logic [2:0] {
		RATE_NORMAL = 3'b001,
		RATE_SLOW = 3'b010,
		RATE_FAST = 3'b100
	} slew_mode_t;
	typedef enum logic [2:0] {
		WAKE_IDLE = 3'b001,
		WAKE_DOM = 3'b010,
		WAKE_LONG = 3'b100
	} wake_state_t;
endpackage : lin_phy_pkg

// ### rtl/lin_phy_control.sv
// bus physical-layer control: edge rate, thermal and supply protection, wake, line routing
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "lin_phy_params.svh"
// Functional notes
// - Two-bit field picks 10k, 20k or 100k edge rate; reset gives 20k.
// - Field 00 and 11 normal, 01 slow, 10 fast.
// - Control bit changes only with its mask bit set; rate field needs mask 11.
// - Over-temperature shuts transmitter off; flag set while condition lasts.
// - Over-temperature interrupt request only while its enable is set.
// - Writing one to status register clears the pending over-temperature request.
// - New over-temperature request only on a fresh onset of the condition.
// - Transmitter returns by itself once cool and transmit input is high.
// - Low-power mode keeps transmitter disabled.
// - Low-power mode keeps receiver running for wake detection.
// - Dominant longer than minimum wake time then rising edge signals wake, recorded.
// - Low-voltage disable set and supply low: no new dominant until supply recovers.
// - Disable clear: bus recessive in under-voltage; set: a dominant in progress continues, no new one starts.
// - Under-voltage flag shows the supply low condition.
// - Transmit and receive lines connect to serial interface, port, or register bits.
// - Receive routes out to port pin and timer capture input.
// - No transmission while the module is disabled.
// - Ready flag rises about 50 us after transmitter enable.
// - Bus forced recessive from enable until ready.
module lin_phy_control
	import lin_phy_pkg::*;
#(
	parameter int READY_COUNT = `READY_CYCLES,
	parameter int WAKE_COUNT = `WAKE_DOM_CYCLES
) (
	input wire logic sys_clk_in, // device clock, 25 MHz
	input wire logic rst_b_in, // asynchronous reset, active low
	input wire logic [7:0] addr_in, // register address
	input wire logic [15:0] wdata_in, // register write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [15:0] rdata_out, // read data, cycle after strobe
	input wire logic overtemp_in, // thermal sensor, asynchronous
	input wire logic supply_low_in, // supply below threshold, asynchronous
	input wire logic bus_rx_in, // receiver comparator, high is recessive
	input wire logic low_power_in, // device in low-power mode
	input wire logic sci_tx_in, // serial interface transmit
	input wire logic port_tx_in, // port pin transmit source
	output logic sci_rx_out, // to serial interface receive
	output logic port_rx_out, // to port pin output gate
	output logic timer_capture_out, // bus receive to timer capture
	output logic bus_dominant_out, // driver on: pull bus low
	output logic [1:0] slew_rate_select_out, // selected edge rate field
	output logic [2:0] slew_mode_out, // decoded edge rate, one-hot
	output logic overtemp_irq_out, // over-temperature request
	output logic wake_event_out // wake pulse
);
	// synchroniser stages, first and second flop
	logic ot_m_q;
	logic ot_s_q;
	logic uv_m_q;
	logic uv_s_q;
	logic rx_m_q;
	logic rx_s_q;

	// control register fields and line definitions
	logic overtemp_irq_enable_q;
	logic direct_tx_q;
	logic low_voltage_shutdown_disable_q;
	logic enable_q;
	logic [1:0] slew_rate_select_q;
	logic [1:0] tx_def_q;
	logic [1:0] rx_def_q;

	// protection, ready and wake state
	logic ot_prev_q;
	logic irq_pend_q;
	logic ot_shut_q;
	logic uv_block_q;
	logic ready_q;
	logic wake_src_q;
	logic rx_prev_q;
	logic [15:0] ready_cnt_q;
	logic [15:0] wake_cnt_q;
	wake_state_t wake_q;

	// decodes, transmit path and read path
	slew_mode_t slew_mode;
	logic wr_ctl;
	logic wr_stat;
	logic wr_txd;
	logic wr_rxd;
	logic wr_wake;
	logic tx_src;
	logic tx_want;
	logic tx_allow;
	logic uv_fresh_block;
	logic [15:0] rdata_d;
	logic [7:0] wmask;

	// upper byte of a control write holds one mask bit per control bit
	assign wmask = wdata_in[15:8];
	assign wr_ctl = wr_in && (addr_in == `CTL_OFFSET);
	assign wr_stat = wr_in && (addr_in == `STAT_HI_OFFSET);
	assign wr_txd = wr_in && (addr_in == `TX_DEF_OFFSET);
	assign wr_rxd = wr_in && (addr_in == `RX_DEF_OFFSET);
	assign wr_wake = wr_in && (addr_in == `WAKE_SRC_OFFSET);

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ot_m_q <= 1'b0;
			ot_s_q <= 1'b0;
		end else begin
			ot_m_q <= overtemp_in;
			ot_s_q <= ot_m_q;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			uv_m_q <= 1'b0;
			uv_s_q <= 1'b0;
		end else begin
			uv_m_q <= supply_low_in;
			uv_s_q <= uv_m_q;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
		end else begin
			rx_m_q <= bus_rx_in;
			rx_s_q <= rx_m_q;
		end
	end

	// masked control writes
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			overtemp_irq_enable_q <= 1'b0;
			direct_tx_q <= 1'b0;
			low_voltage_shutdown_disable_q <= 1'b0;
			enable_q <= 1'b0;
			slew_rate_select_q <= `SRS_RESET;
		end else if (wr_ctl) begin
			if (wmask[`CTL_OVERTEMP_IRQ_ENABLE_BIT])
				overtemp_irq_enable_q <= wdata_in[`CTL_OVERTEMP_IRQ_ENABLE_BIT];
			if (wmask[`CTL_TXD_BIT])
				direct_tx_q <= wdata_in[`CTL_TXD_BIT];
			if (wmask[`CTL_LOW_VOLTAGE_SHUTDOWN_DISABLE_BIT])
				low_voltage_shutdown_disable_q <= wdata_in[`CTL_LOW_VOLTAGE_SHUTDOWN_DISABLE_BIT];
			if (wmask[`CTL_EN_BIT])
				enable_q <= wdata_in[`CTL_EN_BIT];
			if (wmask[`CTL_SRS_LSB +: 2] == 2'h3)
				slew_rate_select_q <= wdata_in[`CTL_SRS_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_def_q <= 2'h0;
			rx_def_q <= 2'h0;
		end else begin
			if (wr_txd)
				tx_def_q <= wdata_in[1:0];
			if (wr_rxd)
				rx_def_q <= wdata_in[1:0];
		end
	end

	// 00 and 11 both give the normal rate
	always_comb begin
		unique case (slew_rate_select_q)
			2'h1: slew_mode = RATE_SLOW;
			2'h2: slew_mode = RATE_FAST;
			default: slew_mode = RATE_NORMAL;
		endcase
	end

	// over-temperature: onset sets request, write-one clears, set wins
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ot_prev_q <= 1'b0;
			irq_pend_q <= 1'b0;
		end else begin
			ot_prev_q <= ot_s_q;
			if (ot_s_q && !ot_prev_q)
				irq_pend_q <= 1'b1;
			else if (wr_stat && wdata_in[`STAT_OT_BIT])
				irq_pend_q <= 1'b0;
		end
	end
	assign overtemp_irq_out = irq_pend_q && overtemp_irq_enable_q;

	// shutdown holds until cool and transmit source back high
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			ot_shut_q <= 1'b0;
		else if (ot_s_q)
			ot_shut_q <= 1'b1;
		else if (tx_src)
			ot_shut_q <= 1'b0;
	end

	// ready delay after enable
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ready_cnt_q <= 16'h0000;
			ready_q <= 1'b0;
		end else if (!enable_q) begin
			ready_cnt_q <= 16'h0000;
			ready_q <= 1'b0;
		end else if (!ready_q) begin
			if (ready_cnt_q == 16'(READY_COUNT - 1))
				ready_q <= 1'b1;
			ready_cnt_q <= ready_cnt_q + 16'h0001;
		end
	end

	// wake detection on receiver, active in low power
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wake_q <= WAKE_IDLE;
			wake_cnt_q <= 16'h0000;
			rx_prev_q <= 1'b1;
			wake_event_out <= 1'b0;
		end else begin
			rx_prev_q <= rx_s_q;
			wake_event_out <= 1'b0;
			unique case (wake_q)
				WAKE_IDLE: begin
					wake_cnt_q <= 16'h0000;
					if (low_power_in && !rx_s_q)
						wake_q <= WAKE_DOM;
				end
				WAKE_DOM: begin
					if (rx_s_q || !low_power_in)
						wake_q <= WAKE_IDLE;
					else if (wake_cnt_q == 16'(WAKE_COUNT - 1))
						wake_q <= WAKE_LONG;
					else
						wake_cnt_q <= wake_cnt_q + 16'h0001;
				end
				WAKE_LONG: begin
					if (!low_power_in)
						wake_q <= WAKE_IDLE;
					else if (rx_s_q && !rx_prev_q) begin
						wake_event_out <= 1'b1;
						wake_q <= WAKE_IDLE;
					end
				end
				default: begin
					wake_q <= WAKE_IDLE;
					wake_cnt_q <= 16'h0000;
				end
			endcase
		end
	end

	// wake source bit, set wins over write-one clear
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			wake_src_q <= 1'b0;
		else if (wake_event_out)
			wake_src_q <= 1'b1;
		else if (wr_wake && wdata_in[0])
			wake_src_q <= 1'b0;
	end

	// transmit source: high is recessive on serial and port sources
	always_comb begin
		if (tx_def_q[0])
			tx_src = sci_tx_in;
		else if (tx_def_q[1])
			tx_src = port_tx_in;
		else
			tx_src = !direct_tx_q;
	end
	assign tx_want = !tx_src;
	assign tx_allow = enable_q && ready_q
		&& !ot_shut_q && !ot_s_q
		&& !low_power_in
		&& !(uv_s_q && !low_voltage_shutdown_disable_q);

	// low-voltage disable set: once low, no new dominant until supply recovers
	// a registered block alone would let one dominant slip out as the supply drops
	assign uv_fresh_block = uv_s_q && low_voltage_shutdown_disable_q
		&& !bus_dominant_out;
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			uv_block_q <= 1'b0;
		else if (!uv_s_q)
			uv_block_q <= 1'b0;
		else if (low_voltage_shutdown_disable_q && !bus_dominant_out)
			uv_block_q <= 1'b1;
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			bus_dominant_out <= 1'b0;
		else
			bus_dominant_out <= tx_want && tx_allow
				&& !uv_block_q && !uv_fresh_block;
	end

	// receive routing; unrouted serial receive idles high like a recessive bus
	assign sci_rx_out = rx_def_q[0] ? rx_s_q : 1'b1;
	assign port_rx_out = rx_def_q[1] ? rx_s_q : 1'b0;
	assign timer_capture_out = rx_s_q;
	assign slew_rate_select_out = slew_rate_select_q;
	assign slew_mode_out = slew_mode;

	always_comb begin
		rdata_d = 16'h0000;
		unique case (addr_in)
			`CTL_OFFSET: begin
				rdata_d[`CTL_OVERTEMP_IRQ_ENABLE_BIT] = overtemp_irq_enable_q;
				rdata_d[`CTL_TXD_BIT] = direct_tx_q;
				rdata_d[`CTL_LOW_VOLTAGE_SHUTDOWN_DISABLE_BIT] = low_voltage_shutdown_disable_q;
				rdata_d[`CTL_EN_BIT] = enable_q;
				rdata_d[`CTL_SRS_LSB +: 2] = slew_rate_select_q;
			end
			`STAT_HI_OFFSET: begin
				rdata_d[`STAT_OT_BIT] = ot_s_q;
				rdata_d[`STAT_UV_BIT] = uv_s_q;
			end
			`STAT_LO_OFFSET: begin
				rdata_d[`STAT_RDY_BIT] = ready_q;
				rdata_d[`STAT_RX_BIT] = rx_s_q;
				rdata_d[`STAT_TX_BIT] = !bus_dominant_out;
			end
			`TX_DEF_OFFSET: rdata_d[1:0] = tx_def_q;
			`RX_DEF_OFFSET: rdata_d[1:0] = rx_def_q;
			`WAKE_SRC_OFFSET: rdata_d[0] = wake_src_q;
			`LOWPOWER_OFFSET: rdata_d[0] = irq_pend_q;
			default: rdata_d = 16'h0000;
		endcase
	end
	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			rdata_out <= 16'h0000;
		else if (rd_in)
			rdata_out <= rdata_d;
		else
			rdata_out <= 16'h0000;
	end
endmodule : lin_phy_control
`default_nettype wire

// ### verification/lin_node_model.sv
// other node on the single-wire bus: wired level seen by the receiver
`timescale 1ns/100ps
`default_nettype none
module lin_node_model (
	input wire logic dut_dom_in, // device driver on
	input wire logic node_dom_in, // this node pulls low
	output logic bus_level_out // bus, pull-up gives recessive
);
	assign bus_level_out = !(dut_dom_in || node_dom_in);
endmodule : lin_node_model
`default_nettype wire

// ### verification/lin_phy_control_sva.sv
// assertions on the ports of the bus physical-layer control
`timescale 1ns/100ps
`default_nettype none
module lin_phy_control_sva #(
	parameter int READY_COUNT = 8
) (
	input wire logic sys_clk_in, // clock
	input wire logic rst_b_in, // reset
	input wire logic [7:0] addr_in, // address
	input wire logic [15:0] wdata_in, // data
	input wire logic wr_in, // write
	input wire logic overtemp_in, // hot
	input wire logic supply_low_in, // supply low
	input wire logic bus_rx_in, // rx
	input wire logic low_power_in, // low power
	input wire logic bus_dominant_out, // driver
	input wire logic [1:0] slew_rate_select_out, // field
	input wire logic [2:0] slew_mode_out, // decoded
	input wire logic overtemp_irq_out, // request
	input wire logic wake_event_out, // wake
	input wire logic timer_capture_out // rx copy
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	int unsigned age_q;
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			age_q <= 32'hFFFF;
		end else if (wr_in && addr_in == 8'h50 && wdata_in[10] && wdata_in[2]) begin
			age_q <= 32'h0;
		end else if (age_q < 32'hFFFF) begin
			age_q <= age_q + 32'h1;
		end
	end
	ready_hold_a: assert property (
		age_q < READY_COUNT |-> !bus_dominant_out) else $error("dominant before ready");
	slew_decode_a: assert property (
		slew_mode_out == (slew_rate_select_out == 2'h1 ? 3'h2 :
		slew_rate_select_out == 2'h2 ? 3'h4 : 3'h1)) else $error("rate decode wrong");
	slew_mask_a: assert property (
		slew_rate_select_out != $past(slew_rate_select_out) |->
		$past(wr_in && addr_in == 8'h50 && wdata_in[9:8] == 2'h3)) else $error("rate unmasked");
	overtemp_off_a: assert property (
		overtemp_in [*4] |=> !bus_dominant_out) else $error("driver on while hot");
	irq_clear_a: assert property (
		$fell(overtemp_irq_out) |-> $past(wr_in && (addr_in == 8'h52 && wdata_in[7] ||
		addr_in == 8'h50 && wdata_in[15] && !wdata_in[7]))) else $error("request lost");
	low_power_off_a: assert property (
		low_power_in |=> !bus_dominant_out) else $error("driver on in low power");
	uv_no_dom_a: assert property (
		supply_low_in [*4] |=> !$rose(bus_dominant_out)) else $error("dominant in undervoltage");
	wake_cause_a: assert property (
		wake_event_out |-> $past(bus_rx_in, 3) && !$past(bus_rx_in, 4)) else $error("stray wake");
	rx_timer_a: assert property (
		timer_capture_out == $past(bus_rx_in, 2)) else $error("capture not following rx");
endmodule : lin_phy_control_sva
bind lin_phy_control lin_phy_control_sva #(.READY_COUNT(READY_COUNT)) i_sva (.sys_clk_in,
	.rst_b_in, .addr_in, .wdata_in, .wr_in, .overtemp_in, .supply_low_in, .bus_rx_in,
	.low_power_in, .bus_dominant_out, .slew_rate_select_out, .slew_mode_out,
	.overtemp_irq_out, .wake_event_out, .timer_capture_out);
`default_nettype wire

// ### verification/lin_phy_control_test.sv
// self-checking bench of the bus physical-layer control
`timescale 1ns/100ps
`default_nettype none
module lin_phy_control_test;
	logic sys_clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_seen = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic ot = 1'b0, uv = 1'b0, lp = 1'b0, stx = 1'b1, ptx = 1'b1, node_dom = 1'b0;
	logic rx, srx, prx, cap, dom, irq, wake;
	logic [1:0] sel;
	logic [2:0] mode;
	logic [31:0] exp_q[$];
	int n_errors = 0, cmp_count = 0, cyc = 0;
	always #20 sys_clk_in = ~sys_clk_in;
	lin_phy_control #(.READY_COUNT(8), .WAKE_COUNT(8)) i_dut (.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata), .overtemp_in(ot), .supply_low_in(uv), .bus_rx_in(rx),
		.low_power_in(lp), .sci_tx_in(stx), .port_tx_in(ptx), .sci_rx_out(srx),
		.port_rx_out(prx), .timer_capture_out(cap), .bus_dominant_out(dom),
		.slew_rate_select_out(sel), .slew_mode_out(mode), .overtemp_irq_out(irq),
		.wake_event_out(wake));
	lin_node_model i_node (.dut_dom_in(dom), .node_dom_in(node_dom), .bus_level_out(rx));
	task automatic results;
		$display("mismatches %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		addr <= a;
		wdata <= d;
		wr_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge sys_clk_in);
		addr <= a;
		rd_in <= 1'b1;
		exp_q.push_back({m, e});
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
	endtask : rd
	task automatic look(input int n);
		repeat (n) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask : look
	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk_in) begin
		if (rd_seen) begin
			chk("rdata", exp_q[0][15:0] & exp_q[0][31:16], rdata & exp_q[0][31:16]);
			void'(exp_q.pop_front());
		end
		rd_seen <= rd_in;
	end
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		int i;
		logic [1:0] c;
		void'($urandom(32'h48DDF9D0));
		repeat (3) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		rd(8'h50, 16'h0000, 16'hFFFF);
		look(0);
		chk("rx idle", 16'h0005, {13'h0, srx, prx, cap});
		for (i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(8'h50, {8'h03, 6'h00, c});
			rd(8'h50, 16'(c), 16'hFFFF);
			look(0);
			chk("sel", 16'(c), 16'(sel));
			chk("mode", c == 2'h1 ? 16'h0002 : c == 2'h2 ? 16'h0004 : 16'h0001, 16'(mode));
		end
		wr(8'h50, 16'h0202);
		wr(8'h50, {8'h00, 8'($urandom)});
		rd(8'h50, 16'h0003, 16'hFFFF);
		wr(8'h50, 16'h1010);
		look(4);
		chk("dom", 16'h0000, 16'(dom));
		wr(8'h50, 16'h0404);
		look(12);
		chk("dom", 16'h0001, 16'(dom));
		rd(8'h53, 16'h0080, 16'h0080);
		ot <= 1'b1;
		look(6);
		chk("dom", 16'h0000, 16'(dom));
		chk("irq", 16'h0000, 16'(irq));
		rd(8'h52, 16'h0080, 16'h0088);
		wr(8'h50, 16'h8080);
		look(1);
		chk("irq", 16'h0001, 16'(irq));
		wr(8'h52, 16'h0080);
		look(4);
		chk("irq", 16'h0000, 16'(irq));
		@(posedge sys_clk_in);
		ot <= 1'b0;
		look(6);
		chk("dom", 16'h0000, 16'(dom));
		wr(8'h50, 16'h1000);
		wr(8'h50, 16'h1010);
		look(3);
		chk("dom", 16'h0001, 16'(dom));
		@(posedge sys_clk_in);
		uv <= 1'b1;
		look(6);
		chk("dom", 16'h0000, 16'(dom));
		rd(8'h52, 16'h0008, 16'h0088);
		wr(8'h50, 16'h0808);
		look(4);
		chk("dom", 16'h0000, 16'(dom));
		wr(8'h50, 16'h0800);
		uv <= 1'b0;
		ot <= 1'b1;
		look(6);
		chk("irq", 16'h0001, 16'(irq));
		wr(8'h52, 16'h0080);
		ot <= 1'b0;
		wr(8'h50, 16'h1000);
		wr(8'h55, 16'h0003);
		wr(8'h54, 16'h0001);
		for (i = 0; i < 6; i++) begin
			@(posedge sys_clk_in);
			stx <= 1'($urandom);
			look(5);
			chk("dom", 16'(!stx), 16'(dom));
			chk("rx", {13'h0, stx, stx, stx}, {13'h0, srx, prx, cap});
		end
		wr(8'h54, 16'h0002);
		ptx <= 1'b0;
		look(4);
		chk("dom", 16'h0001, 16'(dom));
		@(posedge sys_clk_in);
		lp <= 1'b1;
		look(3);
		chk("dom", 16'h0000, 16'(dom));
		@(posedge sys_clk_in);
		node_dom <= 1'b1;
		repeat (14) @(posedge sys_clk_in);
		node_dom <= 1'b0;
		for (i = 0; i < 12 && wake !== 1'b1; i++) begin
			@(negedge sys_clk_in);
		end
		chk("wake", 16'h0001, 16'(wake));
		rd(8'h58, 16'h0001, 16'h0001);
		wr(8'h58, 16'h0001);
		rd(8'h58, 16'h0000, 16'h0001);
		repeat (3) @(posedge sys_clk_in);
		results();
	end
endmodule : lin_phy_control_test
`default_nettype wire
